// file: rtl/magic_packet_detector.sv
// magic packet detector: watches received frame bytes for a wake-up
// pattern, holds the received flag and raises the chosen notification.
// assumes the rx byte stream and all control inputs run on sys_clk_in,
// one byte per cycle when rx_valid_in is high, last byte marked.
`default_nettype none
`include "magic_packet_detector_cfg.svh"

module magic_packet_detector (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic magic_detect_enable_in,
  input wire logic light_sleep_state_in,
  input wire logic notify_select_in,
  input wire logic flag_clear_in,
  input wire logic [47:0] station_addr_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  output logic rx_pass_valid_out,
  output logic [7:0] rx_pass_data_out,
  output logic rx_pass_last_out,
  output logic detect_active_out,
  output logic wake_frame_detect_en_out,
  output logic magic_received_flag_out,
  output logic irq_out,
  output logic power_event_output_out
);

  // scanner state
  magic_packet_pkg::scan_state_e state_r;
  magic_packet_pkg::scan_state_e state_nxt;
  logic [3:0] pos_r;
  logic [3:0] pos_nxt;
  logic [2:0] sync_cnt_r;
  logic [2:0] sync_cnt_nxt;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [3:0] rep_r;
  logic [3:0] rep_nxt;
  logic hit;

  // status and notification
  logic flag_r;
  logic flag_nxt;
  logic irq_r;
  logic irq_nxt;
  logic pwr_r;
  logic pwr_nxt;
  logic active_r;
  logic active_nxt;
  logic wake_en_r;
  logic wake_en_nxt;

  // normal receive path
  logic pass_valid_r;
  logic pass_valid_nxt;
  logic [7:0] pass_data_r;
  logic [7:0] pass_data_nxt;
  logic pass_last_r;
  logic pass_last_nxt;

  logic active;
  logic dest_ok;
  logic hdr_byte;
  logic is_sync;
  logic addr_match;

  // full power needs the enable bit; light sleep forces detection on
  assign active = magic_detect_enable_in | light_sleep_state_in;
  assign hdr_byte = rx_valid_in && active && (state_r == magic_packet_pkg::ST_HEADER);
  assign is_sync = (rx_data_in == `MPD_SYNC_VALUE);
  assign addr_match = (rx_data_in == magic_packet_pkg::addr_byte(station_addr_in, idx_r));

  dest_addr_classifier u_dest (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .byte_valid_in(hdr_byte),
    .byte_idx_in(pos_r),
    .byte_in(rx_data_in),
    .station_addr_in(station_addr_in),
    .dest_ok_out(dest_ok)
  );

  // ---- pattern scanner
  always_comb begin
    state_nxt = state_r;
    pos_nxt = pos_r;
    sync_cnt_nxt = sync_cnt_r;
    idx_nxt = idx_r;
    rep_nxt = rep_r;
    hit = 1'b0;
    if (!active) begin
      // detection off: scanner idles at the start of a frame
      state_nxt = magic_packet_pkg::ST_HEADER;
      pos_nxt = `MPD_RST_POS;
      sync_cnt_nxt = `MPD_RST_SYNC;
      idx_nxt = `MPD_RST_IDX;
      rep_nxt = `MPD_RST_REP;
    end else if (rx_valid_in) begin
      unique case (state_r)
        magic_packet_pkg::ST_HEADER: begin
          // skip destination and source address fields
          pos_nxt = pos_r + 4'd1;
          if (pos_r == `MPD_HDR_BYTES - 4'd1) begin
            state_nxt = magic_packet_pkg::ST_SEARCH;
            sync_cnt_nxt = `MPD_RST_SYNC;
          end
        end
        magic_packet_pkg::ST_SEARCH: begin
          if (is_sync) begin
            if (sync_cnt_r == `MPD_SYNC_LAST) begin
              // six all-ones bytes seen
              state_nxt = magic_packet_pkg::ST_MATCH;
              idx_nxt = `MPD_RST_IDX;
              rep_nxt = `MPD_RST_REP;
            end else begin
              sync_cnt_nxt = sync_cnt_r + 3'd1;
            end
          end else begin
            sync_cnt_nxt = `MPD_RST_SYNC;
          end
        end
        magic_packet_pkg::ST_MATCH: begin
          if (addr_match) begin
            if (idx_r == `MPD_ADDR_LAST) begin
              idx_nxt = `MPD_RST_IDX;
              if (rep_r == `MPD_REPS_LAST) begin
                // sixteenth copy complete
                state_nxt = magic_packet_pkg::ST_DONE;
                hit = dest_ok;
              end else begin
                rep_nxt = rep_r + 4'd1;
              end
            end else begin
              idx_nxt = idx_r + 3'd1;
            end
          end else if (is_sync && (rep_r == `MPD_RST_REP) && (idx_r == `MPD_RST_IDX)) begin
            // a longer all-ones run still counts as the sync stream
            state_nxt = magic_packet_pkg::ST_MATCH;
          end else begin
            // break in the copies: search the rest of the frame again
            state_nxt = magic_packet_pkg::ST_SEARCH;
            sync_cnt_nxt = is_sync ? 3'd1 : `MPD_RST_SYNC;
            idx_nxt = `MPD_RST_IDX;
            rep_nxt = `MPD_RST_REP;
          end
        end
        magic_packet_pkg::ST_DONE: begin
          state_nxt = magic_packet_pkg::ST_DONE;
        end
      endcase
      if (rx_last_in) begin
        // progress never spans two frames
        state_nxt = magic_packet_pkg::ST_HEADER;
        pos_nxt = `MPD_RST_POS;
        sync_cnt_nxt = `MPD_RST_SYNC;
        idx_nxt = `MPD_RST_IDX;
        rep_nxt = `MPD_RST_REP;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= magic_packet_pkg::ST_HEADER;
      pos_r <= `MPD_RST_POS;
      sync_cnt_r <= `MPD_RST_SYNC;
      idx_r <= `MPD_RST_IDX;
      rep_r <= `MPD_RST_REP;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
      pos_r <= pos_nxt;
      sync_cnt_r <= sync_cnt_nxt;
      idx_r <= idx_nxt;
      rep_r <= rep_nxt;
    end
  end

  // ---- status flag and notification
  always_comb begin
    // a detection in the clearing cycle wins over the clear
    flag_nxt = hit | (flag_r & ~flag_clear_in);
    // notify on the line chosen by notify_select_in
    irq_nxt = flag_nxt & (notify_select_in == `MPD_NOTIFY_IRQ);
    pwr_nxt = flag_nxt & (notify_select_in == `MPD_NOTIFY_PWR);
    active_nxt = active;
    // wake-up frame detection is forced on in light sleep
    wake_en_nxt = light_sleep_state_in;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_r <= `MPD_RST_FLAG;
      irq_r <= 1'b0;
      pwr_r <= 1'b0;
      active_r <= 1'b0;
      wake_en_r <= 1'b0;
    end else if (clk_en_in) begin
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
      pwr_r <= pwr_nxt;
      active_r <= active_nxt;
      wake_en_r <= wake_en_nxt;
    end
  end

  // ---- normal receive path, blocked while detection is active
  always_comb begin
    pass_valid_nxt = rx_valid_in & ~active;
    pass_last_nxt = rx_valid_in & rx_last_in & ~active;
    pass_data_nxt = pass_data_r;
    if (rx_valid_in && !active) begin
      pass_data_nxt = rx_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pass_valid_r <= 1'b0;
      pass_data_r <= `MPD_RST_BYTE;
      pass_last_r <= 1'b0;
    end else if (clk_en_in) begin
      pass_valid_r <= pass_valid_nxt;
      pass_data_r <= pass_data_nxt;
      pass_last_r <= pass_last_nxt;
    end
  end

  assign rx_pass_valid_out = pass_valid_r;
  assign rx_pass_data_out = pass_data_r;
  assign rx_pass_last_out = pass_last_r;
  assign detect_active_out = active_r;
  assign wake_frame_detect_en_out = wake_en_r;
  assign magic_received_flag_out = flag_r;
  assign irq_out = irq_r;
  assign power_event_output_out = pwr_r;

endmodule : magic_packet_detector

`default_nettype wire

// file: include/magic_packet_detector_cfg.svh
// constants for the magic packet detector: pattern lengths, header size,
// sync value, notify selection codes and reset values.
// assumes inclusion by bare name from design and bench files.
`ifndef MAGIC_PACKET_DETECTOR_CFG_SVH
`define MAGIC_PACKET_DETECTOR_CFG_SVH

// destination and source address fields precede the searched payload
`define MPD_HDR_BYTES 4'd12
// last byte index of the destination address field
`define MPD_DEST_LAST 4'd5
// synchronization stream length and byte value
`define MPD_SYNC_LAST 3'd5
`define MPD_SYNC_VALUE 8'hff
// station address length (last byte index) and repetitions (last index)
`define MPD_ADDR_LAST 3'd5
`define MPD_REPS_LAST 4'd15
// notify selection on notify_select_in
`define MPD_NOTIFY_IRQ 1'b0
`define MPD_NOTIFY_PWR 1'b1
// reset values
`define MPD_RST_FLAG 1'b0
`define MPD_RST_POS 4'h0
`define MPD_RST_SYNC 3'h0
`define MPD_RST_IDX 3'h0
`define MPD_RST_REP 4'h0
`define MPD_RST_BYTE 8'h00

`endif

// file: include/magic_packet_pkg.sv
// types shared by the magic packet detector files.
// assumes nothing of its surroundings.
`default_nettype none

package magic_packet_pkg;

  typedef enum logic [1:0] {
    ST_HEADER,
    ST_SEARCH,
    ST_MATCH,
    ST_DONE
  } scan_state_e;

  typedef logic [7:0] byte_t;
  typedef logic [47:0] mac_addr_t;

  // byte i of the station address in transmitted order, byte 0 first
  function automatic byte_t addr_byte(input mac_addr_t addr, input logic [2:0] idx);
    return addr[{idx, 3'b000} +: 8];
  endfunction : addr_byte

endpackage : magic_packet_pkg

`default_nettype wire

// file: rtl/dest_addr_classifier.sv
// destination address classifier for the magic packet detector.
// assumes header bytes arrive with their index on the rx clock.
`default_nettype none
`include "magic_packet_detector_cfg.svh"

module dest_addr_classifier (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic byte_valid_in,
  input wire logic [3:0] byte_idx_in,
  input wire logic [7:0] byte_in,
  input wire logic [47:0] station_addr_in,
  output logic dest_ok_out
);

  logic ucast_r;
  logic ucast_nxt;
  logic bcast_r;
  logic bcast_nxt;
  logic mcast_r;
  logic mcast_nxt;
  logic first;
  logic in_dest;

  always_comb begin
    ucast_nxt = ucast_r;
    bcast_nxt = bcast_r;
    mcast_nxt = mcast_r;
    first = (byte_idx_in == `MPD_RST_POS);
    in_dest = byte_valid_in && (byte_idx_in <= `MPD_DEST_LAST);
    if (in_dest) begin
      // own unicast address, byte by byte
      ucast_nxt = (first || ucast_r) &&
                  (byte_in == magic_packet_pkg::addr_byte(station_addr_in, byte_idx_in[2:0]));
      // all-ones broadcast address
      bcast_nxt = (first || bcast_r) && (byte_in == `MPD_SYNC_VALUE);
      // group bit of the first destination byte marks multicast
      if (first) begin
        mcast_nxt = byte_in[0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ucast_r <= 1'b0;
      bcast_r <= 1'b0;
      mcast_r <= 1'b0;
    end else if (clk_en_in) begin
      ucast_r <= ucast_nxt;
      bcast_r <= bcast_nxt;
      mcast_r <= mcast_nxt;
    end
  end

  assign dest_ok_out = ucast_r | bcast_r | mcast_r;

endmodule : dest_addr_classifier

`default_nettype wire

// file: tb/rx_byte_source.sv
// far-side model: mac receive path sending one frame of stored bytes.
// assumes the bench fills mem and len_in before pulsing go_in.
`default_nettype none
module rx_byte_source (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic slow_in,
  input wire logic [7:0] len_in,
  output logic valid_out,
  output logic [7:0] data_out,
  output logic last_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] pos_r;
  logic hold_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {valid_out, data_out, last_out, busy_out, pos_r, hold_r} <= '0;
    end else begin
      valid_out <= 1'b0;
      last_out <= 1'b0;
      // idle data toggles so a stale byte is never mistaken for a fresh one
      data_out <= ~data_out;
      if (go_in && !busy_out) begin
        busy_out <= 1'b1;
        pos_r <= 8'h00;
      end else if (busy_out && slow_in && !hold_r) begin
        hold_r <= 1'b1;
      end else if (busy_out) begin
        hold_r <= 1'b0;
        valid_out <= 1'b1;
        data_out <= mem[pos_r];
        last_out <= (pos_r == len_in - 8'h01);
        busy_out <= (pos_r != len_in - 8'h01);
        pos_r <= pos_r + 8'h01;
      end
    end
  end
endmodule : rx_byte_source
`default_nettype wire

// file: tb/mpd_sva.sv
// assertions on the magic packet detector ports.
// assumes controls low around reset release; only the detect-active and
// wake-enable checks skip cycles in which clk_en_in holds the block frozen.
`default_nettype none
module mpd_sva (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic magic_detect_enable_in,
  input wire logic light_sleep_state_in,
  input wire logic notify_select_in,
  input wire logic flag_clear_in,
  input wire logic [47:0] station_addr_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  input wire logic rx_pass_valid_out,
  input wire logic [7:0] rx_pass_data_out,
  input wire logic rx_pass_last_out,
  input wire logic detect_active_out,
  input wire logic wake_frame_detect_en_out,
  input wire logic magic_received_flag_out,
  input wire logic irq_out,
  input wire logic power_event_output_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  logic act;
  logic last_addr;
  assign act = magic_detect_enable_in | light_sleep_state_in;
  assign last_addr = act & rx_valid_in & (rx_data_in == station_addr_in[47:40]);
  AST_BLOCK: assert property (rx_valid_in && act |=> !rx_pass_valid_out)
    else $error("byte passed while detecting");
  AST_PASS: assert property (rx_valid_in && !act |=> rx_pass_valid_out
    && rx_pass_data_out == $past(rx_data_in) && rx_pass_last_out == $past(rx_last_in))
    else $error("byte not passed");
  AST_ACTIVE: assert property (clk_en_in |=> detect_active_out == $past(act))
    else $error("detect active wrong");
  AST_WAKE: assert property (clk_en_in |=>
    wake_frame_detect_en_out == $past(light_sleep_state_in))
    else $error("wake detect enable wrong");
  AST_FREEZE: assert property (!clk_en_in |=> $stable(detect_active_out)
    && $stable(magic_received_flag_out))
    else $error("state moved while clock enable low");
  AST_IRQ: assert property (irq_out |-> !$past(notify_select_in))
    else $error("irq with power event selected");
  AST_NOTE: assert property (magic_received_flag_out |-> irq_out ^ power_event_output_out)
    else $error("notify not one-hot with flag");
  AST_RISE: assert property ($rose(magic_received_flag_out) |-> $past(last_addr))
    else $error("flag rose without final address byte");
  AST_STICKY: assert property (magic_received_flag_out && !flag_clear_in |=> magic_received_flag_out)
    else $error("flag dropped");
  AST_CLEAR: assert property (flag_clear_in && !rx_valid_in |=> !magic_received_flag_out)
    else $error("flag not cleared");
  cover property ($rose(irq_out));
  cover property ($rose(power_event_output_out));
  cover property (rx_pass_valid_out && rx_pass_last_out);
  cover property (magic_received_flag_out && flag_clear_in);
endmodule : mpd_sva
bind magic_packet_detector mpd_sva i_sva (.*);
`default_nettype wire

// file: tb/tb.sv
// bench for the magic packet detector: table of frames, then a mid-run reset.
// assumes the byte source model drives the receive side.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] station = 48'h554433221100;
  // row: enable, sleep, select, hit, frame kind
  localparam logic [7:0] rows [11] = '{8'h90, 8'hb1, 8'h92, 8'h83, 8'hb4, 8'h85,
    8'h00, 8'h70, 8'h51, 8'h86, 8'h87};
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic en = 1'b0, sleep = 1'b0, sel = 1'b0, clr = 1'b0, go = 1'b0, slow = 1'b0;
  logic ce = 1'b1;
  logic [7:0] len = 8'h00;
  logic [7:0] rx_data;
  logic rx_valid, rx_last, busy, pass_v, active, wake, flag, irq, pwr;
  int n_fail = 0, samples_checked = 0, n_pass = 0, cycles = 0, base;
  always #5 sys_clk_in = ~sys_clk_in;
  rx_byte_source i_src (.clk_in(sys_clk_in), .rst_in(rst_in), .go_in(go), .slow_in(slow),
    .len_in(len), .valid_out(rx_valid), .data_out(rx_data), .last_out(rx_last),
    .busy_out(busy));
  magic_packet_detector i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(ce),
    .magic_detect_enable_in(en), .light_sleep_state_in(sleep), .notify_select_in(sel),
    .flag_clear_in(clr), .station_addr_in(station), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_last_in(rx_last), .rx_pass_valid_out(pass_v),
    .rx_pass_data_out(), .rx_pass_last_out(), .detect_active_out(active),
    .wake_frame_detect_en_out(wake), .magic_received_flag_out(flag), .irq_out(irq),
    .power_event_output_out(pwr));
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (pass_v === 1'b1) n_pass <= n_pass + 1;
    if (cycles == 6000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic put(inout int n, input logic [7:0] b);
    i_src.mem[n] = b;
    n++;
  endtask : put
  task automatic reps(inout int n, input int k);
    for (int i = 0; i < 6; i++) put(n, 8'hff);
    for (int i = 0; i < 6 * k; i++) put(n, station[8 * (i % 6) +: 8]);
  endtask : reps
  // kinds: 0 own, 1 broadcast, 2 multicast, 3 other, 4 broken, 5 short, 6/7 split
  task automatic load(input int kind);
    int n;
    n = 0;
    for (int i = 0; i < 6; i++) put(n, kind == 1 ? 8'hff : kind == 2 ? 8'h01 :
      kind == 3 ? 8'h02 : station[8 * i +: 8]);
    for (int i = 0; i < 7; i++) put(n, 8'h10);
    if (kind == 4) reps(n, 3);
    if (kind == 4) put(n, 8'h77);
    if (kind == 7) for (int i = 0; i < 48; i++) put(n, station[8 * (i % 6) +: 8]);
    else reps(n, kind == 5 ? 15 : kind == 6 ? 8 : 16);
    put(n, 8'h99);
    len <= n[7:0];
  endtask : load
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    foreach (rows[r]) begin
      @(posedge sys_clk_in);
      {en, sleep, sel} <= rows[r][7:5];
      clr <= 1'b1;
      slow <= r[0];
      load(int'(rows[r][3:0]));
      @(posedge sys_clk_in);
      clr <= 1'b0;
      @(negedge sys_clk_in);
      check("flag after clear", 8'h00, 8'(flag));
      base = n_pass;
      @(posedge sys_clk_in);
      go <= 1'b1;
      @(posedge sys_clk_in);
      go <= 1'b0;
      @(negedge sys_clk_in);
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge sys_clk_in);
      repeat (3) @(negedge sys_clk_in);
      check("flag", 8'(rows[r][4]), 8'(flag));
      check("irq", 8'(rows[r][4] & ~rows[r][5]), 8'(irq));
      check("power event", 8'(rows[r][4] & rows[r][5]), 8'(pwr));
      check("passed bytes", |rows[r][7:6] ? 8'h00 : len, 8'(n_pass - base));
      check("active", 8'(|rows[r][7:6]), 8'(active));
      check("wake detect", 8'(rows[r][6]), 8'(wake));
      @(posedge sys_clk_in);
      sel <= ~rows[r][5];
      repeat (2) @(negedge sys_clk_in);
      check("irq after swap", 8'(rows[r][4] & rows[r][5]), 8'(irq));
    end
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check("outputs in reset", 8'h00, 8'({flag, irq, pwr, active, wake, pass_v}));
    en <= 1'b0;
    sleep <= 1'b0;
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check("outputs after release", 8'h00, 8'({flag, irq, pwr, active, wake, pass_v}));
    // a hit while the clear is held still sets the flag
    @(posedge sys_clk_in);
    {en, sel, clr, slow} <= 4'b1010;
    load(0);
    @(posedge sys_clk_in);
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    for (int i = 0; i < 400 && flag !== 1'b1; i++) @(negedge sys_clk_in);
    check("flag set over clear", 8'h01, 8'(flag));
    @(negedge sys_clk_in);
    check("flag after held clear", 8'h00, 8'(flag));
    // clock enable low freezes the registered state
    @(posedge sys_clk_in);
    {ce, en, clr} <= 3'b000;
    repeat (3) @(negedge sys_clk_in);
    check("active while frozen", 8'h01, 8'(active));
    @(posedge sys_clk_in);
    ce <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check("active after freeze", 8'h00, 8'(active));
    repeat (2) @(posedge sys_clk_in);
    conclude();
  end
endmodule : tb
`default_nettype wire
